// ==== io_pass_pkg.sv ====
// Shared constants for the I/O line-passing output control block.
// Assumes a single 200 MHz clock and a byte-addressed register port.
package io_pass_pkg;

  // Clock and timeout base
  localparam int CLK_FREQ_KHZ   = 200000;   // 200 MHz system clock
  localparam int TICK_PERIOD_MS = 100;      // Timeout unit is 100 ms
  localparam int TICK_CYCLES    = TICK_PERIOD_MS * CLK_FREQ_KHZ;

  // Sizes
  localparam int NUM_LINES   = 8;           // Digital lines zero..seven
  localparam int NUM_PULSE   = 2;           // Pulse-width outputs
  localparam int DUTY_W      = 10;          // Analog sample and duty width
  localparam int TMO_W       = 16;          // Timeout setting width
  localparam int ADDR_W      = 8;           // Register byte address width
  localparam int CFG_W       = 3;           // Line mode field width

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] SRC_ADDR_OFS  = 8'h04;
  localparam logic [7:0] APT_OFS       = 8'h08;
  localparam logic [7:0] PRESET0_OFS   = 8'h0C;
  localparam logic [7:0] PRESET1_OFS   = 8'h10;
  localparam logic [7:0] LINE_CFG_OFS  = 8'h14;
  localparam logic [7:0] PULL_OFS      = 8'h18;
  localparam logic [7:0] DIRECT_OFS    = 8'h1C;
  localparam logic [7:0] CHG_MASK_OFS  = 8'h20;
  localparam logic [7:0] STATUS_OFS    = 8'h24;
  localparam logic [7:0] DUTY_NOW_OFS  = 8'h28;
  localparam logic [7:0] DTMO_BASE_OFS = 8'h40;  // Eight words, one a line

  // Control, status and duty-now register fields
  localparam int CTRL_API_BIT = 0;          // Framed API serial mode
  localparam int CTRL_FWD_BIT = 1;          // forward_sample_to_serial
  localparam int STAT_SLEEP_BIT = 10;       // Status: asleep
  localparam int DUTY1_LSB      = 16;       // Second duty in duty-now word

  // Reset values and broadcast address
  localparam logic [31:0] CTRL_RST     = 32'h0000_0002;
  localparam logic [15:0] SRC_ADDR_RST = 16'hFFFF;
  localparam logic [15:0] BCAST_ADDR   = 16'hFFFF;

  // Line modes
  localparam logic [2:0] MODE_DISABLED = 3'h0;
  localparam logic [2:0] MODE_INPUT    = 3'h3;
  localparam logic [2:0] MODE_OUT_LOW  = 3'h4;
  localparam logic [2:0] MODE_OUT_HIGH = 3'h5;

endpackage : io_pass_pkg

// ==== hold_timer.sv ====
// Countdown in timeout ticks; pulses expire when a loaded hold runs out.
// Assumes tick is a one-cycle pulse on the same clock, gated off in sleep.
`timescale 1ns/100ps
`default_nettype none
module hold_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         load,     // Start a new hold
  input  wire logic [W-1:0] period,   // Hold length in ticks
  input  wire logic         tick,     // Time base pulse
  output logic              expire    // One-cycle end of hold
);

  // Timer state
  typedef struct packed {
    logic [W-1:0] cnt;      // Ticks left, zero means idle
    logic         expire;   // Expiry pulse
  } timer_state_type;

  timer_state_type q;       // Registered state
  timer_state_type d;       // Next state

  // Next-state logic; a fresh load wins over a pending expiry
  always_comb begin
    d        = q;
    d.expire = 1'b0;
    if (load) begin
      d.cnt = period;       // Zero period holds with no reversion
    end else if (tick && q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
      if (q.cnt == W'(1)) begin
        d.expire = 1'b1;
      end
    end
  end

  // State register; holding on low ce pauses the count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign expire = q.expire;

endmodule // hold_timer
`default_nettype wire

// ==== pulse_gen.sv ====
// Free-running pulse-width generator with a forced-low sleep input.
// Assumes duty is stable in the clock domain; output is registered.
`timescale 1ns/100ps
`default_nettype none
module pulse_gen #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         force_low,  // Shut the output down
  input  wire logic [W-1:0] duty,       // High count per period
  output logic              pulse       // Registered pulse output
);

  // Generator state
  typedef struct packed {
    logic [W-1:0] cnt;    // Period counter
    logic         pulse;  // Output level
  } pulse_state_type;

  pulse_state_type q;     // Registered state
  pulse_state_type d;     // Next state

  // Average level tracks duty over 2**W cycles
  always_comb begin
    d       = q;
    d.cnt   = q.cnt + 1'b1;
    d.pulse = !force_low && (q.cnt < duty);
    if (force_low) begin
      d.cnt = '0;         // Restart cleanly on wake
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign pulse = q.pulse;

endmodule // pulse_gen
`default_nettype wire

// ==== io_pass_ctrl.sv ====
// Receiver-side output control for I/O line passing: digital and
// pulse-width outputs driven from remote samples, timeouts, direct set,
// serial forwarding decision and sleep handling.
// Assumes sample, sleep and register strobes come from same-clock logic.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Analog input n drives pulse output n
// - One analog timeout for both pulse outputs
// - Pulse output reverts to preset after timeout
// - Only matching source address drives outputs
// - Broadcast input address accepts any source
// - Passing works in API and transparent modes
// - Forward setting zero drops matching frames
// - Non-matching samples forwarded in API mode only
// - Direct set drives lines configured output
// - Direct-set levels never revert on timeout
// - Direct-set change visible to change detection
// - Sleep holds digital outputs, keeps pull configuration
// - Sleep drives peripherals low, SPI high
// - Sleep holds passed values, pauses timers
// - Pulse outputs low during sleep
// - Wake returns passed pulse outputs to preset
// - Sampled digital copies to matching output line
// - Per-line timeout restores configured output
module io_pass_ctrl
  import io_pass_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES   // Cycles per timeout tick
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // Register port
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  // Received sample from the radio side
  input  wire logic                  sample_valid,
  input  wire logic [15:0]           sample_src,
  input  wire logic [NUM_LINES-1:0]  sample_dmask,
  input  wire logic [NUM_LINES-1:0]  sample_dval,
  input  wire logic [NUM_PULSE-1:0]  sample_amask,
  input  wire logic [DUTY_W-1:0]     analog_input_zero,
  input  wire logic [DUTY_W-1:0]     analog_input_one,
  // Power manager
  input  wire logic                  sleep_active,
  // Serial forwarding decision
  output logic                       fwd_valid,
  output logic                       fwd_drop,
  // Digital lines
  output logic      [NUM_LINES-1:0]  dio_out,
  output logic      [NUM_LINES-1:0]  dio_oe_n,
  output logic      [NUM_LINES-1:0]  dio_pull_en,
  output logic      [NUM_LINES-1:0]  dio_pull_up,
  output logic                       change_event,
  // Pulse-width outputs
  output logic                       pulse_output_zero,
  output logic                       pulse_output_one,
  // Peripheral pin sleep states
  output logic                       periph_hold_low,
  output logic                       spi_hold_high
);

  localparam int PRE_W = $clog2(TICK_CNT + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CNT - 1);

  // All block state
  typedef struct packed {
    logic [31:0]                      ctrl;        // Mode and forward
    logic [15:0]                      src_addr;    // input_source_address
    logic [TMO_W-1:0]                 apt;         // analog_pass_timeout
    logic [NUM_PULSE-1:0][DUTY_W-1:0] preset;      // duty_preset_*
    logic [NUM_LINES-1:0][CFG_W-1:0]  line_cfg;    // line_*_config
    logic [NUM_LINES-1:0]             pull_en;     // pull_resistor_enable
    logic [NUM_LINES-1:0]             pull_dir;    // pull_direction
    logic [NUM_LINES-1:0]             chg_mask;    // change_detect_mask
    logic [NUM_LINES-1:0][TMO_W-1:0]  dtmo;        // digital_line_timeout_*
    logic [NUM_LINES-1:0]             level;       // Configured or direct
    logic [NUM_LINES-1:0]             dpass;       // Line held by passing
    logic [NUM_LINES-1:0]             dpass_val;   // Passed level
    logic [NUM_PULSE-1:0]             apass;       // Pulse held by passing
    logic [NUM_PULSE-1:0][DUTY_W-1:0] apass_duty;  // Passed duty
    logic [NUM_PULSE-1:0][DUTY_W-1:0] duty;        // Duty in use
    logic [NUM_LINES-1:0]             dload;       // Start line hold
    logic [NUM_PULSE-1:0]             aload;       // Start pulse hold
    logic [PRE_W-1:0]                 pre;         // Tick prescaler
    logic                             tick;        // Timeout tick
    logic                             sleep_prev;  // For wake edge
    logic [31:0]                      rdata;       // Read answer
    logic                             fwd_valid;
    logic                             fwd_drop;
    logic [NUM_LINES-1:0]             dio_out;
    logic [NUM_LINES-1:0]             dio_oe_n;
    logic [NUM_LINES-1:0]             pull_en_o;
    logic [NUM_LINES-1:0]             pull_up_o;
    logic                             change_event;
    logic                             periph_low;
    logic                             spi_high;
  } ctrl_state_type;

  ctrl_state_type q;                    // Registered state
  ctrl_state_type d;                    // Next state

  logic [NUM_LINES-1:0] dexp;           // Line hold expired
  logic [NUM_PULSE-1:0] aexp;           // Pulse hold expired
  logic [NUM_PULSE-1:0][DUTY_W-1:0] asample; // Samples by channel

  assign asample[0] = analog_input_zero;
  assign asample[1] = analog_input_one;

  // Line is a driven output in mode 4 or 5
  function automatic logic is_out(input logic [CFG_W-1:0] m);
    return (m == MODE_OUT_LOW) || (m == MODE_OUT_HIGH);
  endfunction

  // Main next-state logic
  always_comb begin
    logic match;                        // Sample source accepted
    logic wake;                         // Sleep just ended
    int   idx;                          // Timeout word index
    match = 1'b0;
    wake  = 1'b0;
    idx   = 0;
    d              = q;
    d.fwd_valid    = 1'b0;
    d.fwd_drop     = 1'b0;
    d.change_event = 1'b0;
    d.tick         = 1'b0;
    d.dload        = '0;
    d.aload        = '0;
    d.rdata        = '0;
    d.sleep_prev   = sleep_active;

    // Time base stops in sleep so holds resume where they paused
    if (!sleep_active) begin
      if (q.pre >= PRE_LAST) begin
        d.pre  = '0;
        d.tick = 1'b1;
      end else begin
        d.pre = q.pre + 1'b1;
      end
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        CTRL_OFS:     d.ctrl     = {30'h0000_0000, reg_wdata[1:0]};
        SRC_ADDR_OFS: d.src_addr = reg_wdata[15:0];
        APT_OFS:      d.apt      = reg_wdata[TMO_W-1:0];
        PRESET0_OFS:  d.preset[0] = reg_wdata[DUTY_W-1:0];
        PRESET1_OFS:  d.preset[1] = reg_wdata[DUTY_W-1:0];
        LINE_CFG_OFS: begin
          d.line_cfg = reg_wdata[NUM_LINES*CFG_W-1:0];
          for (int i = 0; i < NUM_LINES; i++) begin
            d.level[i] = (d.line_cfg[i] == MODE_OUT_HIGH);
          end
        end
        PULL_OFS: begin
          d.pull_en  = reg_wdata[7:0];
          d.pull_dir = reg_wdata[15:8];
        end
        DIRECT_OFS: begin
          // Only output lines take it; held until written again
          for (int i = 0; i < NUM_LINES; i++) begin
            if (is_out(q.line_cfg[i])) begin
              d.level[i] = reg_wdata[i];
            end
          end
        end
        CHG_MASK_OFS: d.chg_mask = reg_wdata[NUM_LINES-1:0];
        default: begin
          if (reg_addr >= DTMO_BASE_OFS &&
              reg_addr < DTMO_BASE_OFS + 8'(4 * NUM_LINES)) begin
            idx = int'((reg_addr - DTMO_BASE_OFS) >> 2);
            d.dtmo[idx[2:0]] = reg_wdata[TMO_W-1:0];
          end
        end
      endcase
    end

    // Hold expiry returns lines and pulses to their settings
    for (int i = 0; i < NUM_LINES; i++) begin
      if (dexp[i]) begin
        d.dpass[i] = 1'b0;
      end
    end
    for (int j = 0; j < NUM_PULSE; j++) begin
      if (aexp[j]) begin
        d.apass[j] = 1'b0;
      end
    end

    // Wake: passed pulses go back to preset whatever the timer says
    wake = q.sleep_prev && !sleep_active;
    if (wake) begin
      d.apass = '0;
    end

    // Received sample; a new sample wins over a same-cycle expiry
    if (sample_valid) begin
      match = (q.src_addr == BCAST_ADDR) ||
              (sample_src == q.src_addr);
      if (match) begin
        // Mode bit is not consulted: passing in both modes
        for (int i = 0; i < NUM_LINES; i++) begin
          if (sample_dmask[i] && is_out(q.line_cfg[i])) begin
            d.dpass[i]     = 1'b1;
            d.dpass_val[i] = sample_dval[i];
            d.dload[i]     = 1'b1;
          end
        end
        for (int j = 0; j < NUM_PULSE; j++) begin
          if (sample_amask[j]) begin
            d.apass[j]      = 1'b1;
            d.apass_duty[j] = asample[j];
            d.aload[j]      = 1'b1;
          end
        end
      end
      // Transparent mode discards samples after passing
      if (q.ctrl[CTRL_API_BIT]) begin
        if (!match || q.ctrl[CTRL_FWD_BIT]) begin
          d.fwd_valid = 1'b1;
        end else begin
          d.fwd_drop = 1'b1;
        end
      end else begin
        d.fwd_drop = 1'b1;
      end
    end

    // Duty in use: passed value while held, else preset
    for (int j = 0; j < NUM_PULSE; j++) begin
      d.duty[j] = d.apass[j] ? d.apass_duty[j] : d.preset[j];
    end

    // Line drive; passed value sits over the configured level
    for (int i = 0; i < NUM_LINES; i++) begin
      if (is_out(d.line_cfg[i])) begin
        d.dio_out[i]   = d.dpass[i] ? d.dpass_val[i] : d.level[i];
        d.dio_oe_n[i]  = 1'b0;
        d.pull_en_o[i] = 1'b0;
        d.pull_up_o[i] = 1'b0;
      end else begin
        d.dio_out[i]   = 1'b0;
        d.dio_oe_n[i]  = 1'b1;
        d.pull_en_o[i] = d.pull_en[i];
        d.pull_up_o[i] = d.pull_dir[i];
      end
    end

    // An output change on a line set in chg_mask, direct set included, reaches change detect
    if (|((d.dio_out ^ q.dio_out) & d.chg_mask & ~d.dio_oe_n)) begin
      d.change_event = 1'b1;
    end

    // Peripheral pins parked while asleep, released on wake
    d.periph_low = sleep_active;
    d.spi_high   = sleep_active;

    // Read answer, one cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        CTRL_OFS:     d.rdata = q.ctrl;
        SRC_ADDR_OFS: d.rdata = {16'h0000, q.src_addr};
        APT_OFS:      d.rdata = {16'h0000, q.apt};
        PRESET0_OFS:  d.rdata = {22'h00_0000, q.preset[0]};
        PRESET1_OFS:  d.rdata = {22'h00_0000, q.preset[1]};
        LINE_CFG_OFS: d.rdata = {8'h00, q.line_cfg};
        PULL_OFS:     d.rdata = {16'h0000, q.pull_dir, q.pull_en};
        DIRECT_OFS:   d.rdata = {24'h00_0000, q.dio_out};
        CHG_MASK_OFS: d.rdata = {24'h00_0000, q.chg_mask};
        STATUS_OFS: begin
          d.rdata[NUM_LINES-1:0]       = q.dpass;
          d.rdata[NUM_LINES+1:NUM_LINES] = q.apass;
          d.rdata[STAT_SLEEP_BIT]      = q.sleep_prev;
        end
        DUTY_NOW_OFS: begin
          d.rdata[DUTY_W-1:0]                   = q.duty[0];
          d.rdata[DUTY1_LSB+DUTY_W-1:DUTY1_LSB] = q.duty[1];
        end
        default: begin
          if (reg_addr >= DTMO_BASE_OFS &&
              reg_addr < DTMO_BASE_OFS + 8'(4 * NUM_LINES)) begin
            idx = int'((reg_addr - DTMO_BASE_OFS) >> 2);
            d.rdata = {16'h0000, q.dtmo[idx[2:0]]};
          end
        end
      endcase
    end
  end

  // State register; low ce freezes everything
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q          <= '0;
      q.ctrl     <= CTRL_RST;
      q.src_addr <= SRC_ADDR_RST;
      q.dio_oe_n <= '1;
    end else if (ce) begin
      q <= d;
    end
  end

  // Per-line holds; tick is absent in sleep, pausing them
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line_tmr
    hold_timer #(.W(TMO_W)) u_tmr (
      .clk    (clk),
      .rst    (rst),
      .ce     (ce),
      .load   (q.dload[i]),
      .period (q.dtmo[i]),
      .tick   (q.tick),
      .expire (dexp[i])
    );
  end

  // Pulse holds share the one analog timeout setting
  for (genvar j = 0; j < NUM_PULSE; j++) begin : g_pulse_tmr
    hold_timer #(.W(TMO_W)) u_tmr (
      .clk    (clk),
      .rst    (rst),
      .ce     (ce),
      .load   (q.aload[j]),
      .period (q.apt),
      .tick   (q.tick),
      .expire (aexp[j])
    );
  end

  // Pulse generators, forced low through sleep
  pulse_gen #(.W(DUTY_W)) u_pulse0 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .force_low (q.periph_low),
    .duty      (q.duty[0]),
    .pulse     (pulse_output_zero)
  );

  pulse_gen #(.W(DUTY_W)) u_pulse1 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .force_low (q.periph_low),
    .duty      (q.duty[1]),
    .pulse     (pulse_output_one)
  );

  // Outputs straight from the state register
  assign reg_rdata       = q.rdata;
  assign fwd_valid       = q.fwd_valid;
  assign fwd_drop        = q.fwd_drop;
  assign dio_out         = q.dio_out;
  assign dio_oe_n        = q.dio_oe_n;
  assign dio_pull_en     = q.pull_en_o;
  assign dio_pull_up     = q.pull_up_o;
  assign change_event    = q.change_event;
  assign periph_hold_low = q.periph_low;
  assign spi_hold_high   = q.spi_high;

endmodule // io_pass_ctrl
`default_nettype wire

// ==== io_pass_ctrl_assertions.sv ====
// Port-level checks for io_pass_ctrl, attached by bind.
// Assumes ce is held high, so every edge is a working edge.
`timescale 1ns/100ps
`default_nettype none
module io_pass_ctrl_assertions
  import io_pass_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 reg_rd,
  input wire logic                 reg_wr,
  input wire logic [31:0]          reg_rdata,
  input wire logic                 sample_valid,
  input wire logic                 sleep_active,
  input wire logic                 fwd_valid,
  input wire logic                 fwd_drop,
  input wire logic [NUM_LINES-1:0] dio_out,
  input wire logic [NUM_LINES-1:0] dio_oe_n,
  input wire logic [NUM_LINES-1:0] dio_pull_en,
  input wire logic                 change_event,
  input wire logic                 pulse_output_zero,
  input wire logic                 pulse_output_one,
  input wire logic                 periph_hold_low,
  input wire logic                 spi_hold_high
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Read data stands only in the cycle after a read
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero after idle cycle");
  a_fwd_one_of: assert property (
    sample_valid |=> fwd_valid != fwd_drop)
    else $error("sample not given exactly one forward verdict");
  a_fwd_quiet: assert property (
    !sample_valid |=> !fwd_valid && !fwd_drop)
    else $error("forward verdict without a sample");
  a_change_cause: assert property (
    change_event |-> dio_out != $past(dio_out))
    else $error("change event with no line change");
  a_drive_pull: assert property (
    (dio_pull_en & ~dio_oe_n) == '0 && (dio_out & dio_oe_n) == '0)
    else $error("pull on driven line or level on undriven line");
  // Three quiet sleeping edges: nothing may move a line
  a_sleep_hold: assert property (
    (sleep_active && !reg_wr && !sample_valid) [*3] |=> $stable(dio_out))
    else $error("digital line moved while asleep");
  a_pulse_sleep: assert property (
    sleep_active [*4] |-> !pulse_output_zero && !pulse_output_one)
    else $error("pulse output high while asleep");
  a_periph_low: assert property (
    periph_hold_low == $past(sleep_active))
    else $error("peripheral hold does not track sleep");
  a_spi_high: assert property (
    spi_hold_high == $past(sleep_active))
    else $error("serial peripheral hold does not track sleep");
endmodule // io_pass_ctrl_assertions
`default_nettype wire

// ==== io_sample_sender.sv ====
// Remote sampling node model: hands one received I/O sample per call.
// Assumes the receiver takes a sample at the edge where valid is high.
`timescale 1ns/100ps
`default_nettype none
module io_sample_sender
  import io_pass_pkg::*;
(
  input  wire logic                 clk,
  output logic                      sample_valid,
  output logic [15:0]               sample_src,
  output logic [NUM_LINES-1:0]      sample_dmask,
  output logic [NUM_LINES-1:0]      sample_dval,
  output logic [NUM_PULSE-1:0]      sample_amask,
  output logic [DUTY_W-1:0]         analog_input_zero,
  output logic [DUTY_W-1:0]         analog_input_one
);
  // Idle at time zero
  initial begin
    {sample_valid, sample_src, sample_dmask, sample_dval} = '0;
    {sample_amask, analog_input_zero, analog_input_one} = '0;
  end
  // Fields are inverted once released, so stale values never match
  task automatic send(input logic [15:0] s, input logic [7:0] dm, dv,
                      input logic [1:0] am, input logic [9:0] a0, a1);
    @(posedge clk);
    sample_valid <= 1'b1;
    {sample_src, sample_dmask, sample_dval} <= {s, dm, dv};
    {sample_amask, analog_input_zero, analog_input_one} <= {am, a0, a1};
    @(posedge clk);
    sample_valid <= 1'b0;
    {sample_src, sample_dmask, sample_dval} <= ~{s, dm, dv};
    {sample_amask, analog_input_zero, analog_input_one} <= ~{am, a0, a1};
  endtask
endmodule // io_sample_sender
`default_nettype wire

// ==== io_pass_ctrl_tb.sv ====
// Self-checking bench for io_pass_ctrl with a model sampling node.
// Assumes a tick of 10 cycles so every hold lasts tens of cycles.
`timescale 1ns/100ps
`default_nettype none
module io_pass_ctrl_tb;
  import io_pass_pkg::*;
  logic              clk = 1'b0;         // 200 MHz
  logic              rst = 1'b1;         // Async, active high
  logic [ADDR_W-1:0] reg_addr = '0;      // Register bus master side
  logic [31:0]       reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              sleep_active = 1'b0;
  logic [31:0]       reg_rdata;
  logic              sv, fv, fd, ce_ev, pz, po, ph, sh;
  logic [15:0]       src;
  logic [7:0]        dm, dv, dout, doe, pen, pup;
  logic [1:0]        am;
  logic [9:0]        a0, a1;
  int                error_cnt = 0;
  int                n_compared = 0;
  always #2.5 clk = ~clk;
  io_sample_sender io_sample_sender_i (.clk(clk), .sample_valid(sv),
    .sample_src(src), .sample_dmask(dm), .sample_dval(dv),
    .sample_amask(am), .analog_input_zero(a0), .analog_input_one(a1));
  // Clock enable is the one tied input
  io_pass_ctrl #(.TICK_CNT(10)) io_pass_ctrl_i (.clk(clk), .rst(rst),
    .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_valid(sv), .sample_src(src), .sample_dmask(dm),
    .sample_dval(dv), .sample_amask(am), .analog_input_zero(a0),
    .analog_input_one(a1), .sleep_active(sleep_active),
    .fwd_valid(fv), .fwd_drop(fd), .dio_out(dout), .dio_oe_n(doe),
    .dio_pull_en(pen), .dio_pull_up(pup), .change_event(ce_ev),
    .pulse_output_zero(pz), .pulse_output_one(po),
    .periph_hold_low(ph), .spi_hold_high(sh));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read, then sample data in the one cycle it stands
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("register", reg_rdata, exp);
  endtask
  // Sample, then settle on the answer edge
  task automatic pass(input logic [15:0] s, input logic [7:0] m, v);
    io_sample_sender_i.send(s, m, v, 2'b00, 10'h000, 10'h000);
    #1;
  endtask
  task automatic t_reset;
    rchk(CTRL_OFS, CTRL_RST);
    rchk(SRC_ADDR_OFS, 32'h0000_FFFF);
    rchk(8'h3C, 32'h0);
  endtask
  // Lines 0 out low, 1 out high, 2 input; holds of two ticks
  task automatic t_digital;
    wr(LINE_CFG_OFS, 32'h0000_00EC);
    wr(DTMO_BASE_OFS, 32'h2);
    wr(DTMO_BASE_OFS + 8'h04, 32'h2);
    wr(CHG_MASK_OFS, 32'h1);
    chk("oe", 32'(doe), 32'hFC);
    pass(16'h1234, 8'h07, 8'h05);
    chk("out", 32'(dout), 32'h01);
    chk("chg", 32'(ce_ev), 32'h1);
    chk("drop", 32'(fd), 32'h1);
    repeat (8) @(posedge clk);
    #1 chk("held", 32'(dout), 32'h01);
    repeat (30) @(posedge clk);
    #1 chk("revert", 32'(dout), 32'h02);
  endtask
  task automatic t_filter;
    wr(SRC_ADDR_OFS, 32'h0042);
    wr(CTRL_OFS, 32'h3);
    pass(16'h0041, 8'hFF, 8'h00);
    chk("fwd", 32'(fv), 32'h1);
    chk("out", 32'(dout), 32'h02);
    wr(CTRL_OFS, 32'h1);
    pass(16'h0041, 8'hFF, 8'h00);
    chk("fwd", 32'(fv), 32'h1);
    pass(16'h0042, 8'h03, 8'h01);
    chk("drop", 32'(fd), 32'h1);
    chk("out", 32'(dout), 32'h01);
    wr(CTRL_OFS, 32'h3);
    pass(16'h0042, 8'h03, 8'h03);
    chk("fwd", 32'(fv), 32'h1);
    chk("out", 32'(dout), 32'h03);
  endtask
  task automatic t_analog;
    wr(PRESET0_OFS, 32'h64);
    wr(PRESET1_OFS, 32'hC8);
    wr(APT_OFS, 32'h2);
    rchk(DUTY_NOW_OFS, 32'h00C8_0064);
    io_sample_sender_i.send(16'h0042, 8'h0, 8'h0, 2'b11, 10'h155, 10'h2AA);
    rchk(DUTY_NOW_OFS, 32'h02AA_0155);
    io_sample_sender_i.send(16'h0042, 8'h0, 8'h0, 2'b01, 10'h3FF, 10'h0);
    rchk(DUTY_NOW_OFS, 32'h02AA_03FF);
    repeat (30) @(posedge clk);
    rchk(DUTY_NOW_OFS, 32'h00C8_0064);
  endtask
  // Sleep in mid-hold: digital hold paused, pulse holds dropped on wake
  task automatic t_sleep;
    wr(APT_OFS, 32'h0);
    wr(PULL_OFS, 32'h0404);
    io_sample_sender_i.send(16'h0042, 8'h1, 8'h1, 2'b11, 10'h155, 10'h2AA);
    @(posedge clk);
    sleep_active <= 1'b1;
    repeat (60) @(posedge clk);
    #1 chk("out", 32'(dout), 32'h03);
    chk("pwm", 32'({pz, po}), 32'h0);
    chk("hold", 32'({ph, sh}), 32'h3);
    chk("pull", 32'({pen, pup}), 32'h0404);
    @(posedge clk);
    sleep_active <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("out", 32'(dout), 32'h03);
    chk("hold", 32'({ph, sh}), 32'h0);
    rchk(DUTY_NOW_OFS, 32'h00C8_0064);
    repeat (30) @(posedge clk);
    #1 chk("revert", 32'(dout), 32'h02);
  endtask
  // Direct set reaches output lines only and never reverts
  task automatic t_direct;
    wr(DIRECT_OFS, 32'hFF);
    #1 chk("chg", 32'(ce_ev), 32'h1);
    chk("out", 32'(dout), 32'h03);
    wr(DIRECT_OFS, 32'h0);
    repeat (40) @(posedge clk);
    rchk(DIRECT_OFS, 32'h0);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, well past the few hundred cycles the run needs
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_digital();
    t_filter();
    t_analog();
    t_sleep();
    t_direct();
    complete_run();
  end
endmodule // io_pass_ctrl_tb
bind io_pass_ctrl io_pass_ctrl_assertions io_pass_ctrl_assertions_i (.*);
`default_nettype wire
